// >>> hw/fepc_top.sv
// Flash erase/program sequencer with an embedded model flash array and a serial command shifter.
// Assumes requests and the byte streams come from logic on core_clk; serial pins go to an external flash.
// Summary of operation
// - Multi-sector erase takes an eight-bit mask; each set bit erases that sector.
// - Programming only clears bits; a zero never becomes one by programming.
// - Bits return to one only through a sector erase.
// - A read that finds a stored-data error raises the flash error interrupt.
// - A read with invalid parameters reads nothing.
// - The flash error interrupt is raised only while its enable is set.
// - A running counter counts each parity error interrupt.
// - On request while idle, with an external target selected, a power-down command is shifted out to the external flash.
// - After wake a power-up command is sent before any flash access.
// - High-temperature enable selects the high-temperature program and erase voltages.
// - A sector erase leaves every data bit of the sector at one and its parity bits at zero.
`timescale 1ns/100ps
module fepc_top #(
	parameter int SECTORS   = fepc_pkg::SECTORS,
	parameter int SECTOR_AW = fepc_pkg::SECTOR_AW
) (
	input  wire logic                      core_clk,
	input  wire logic                      arst_n,
	input  wire logic                      erase_req,
	input  wire logic [SECTORS-1:0]        sector_erase_mask,
	input  wire logic                      prog_req,
	input  wire logic                      read_req,
	input  wire logic [fepc_pkg::ADDR_W-1:0] flash_byte_offset,
	input  wire logic [fepc_pkg::LEN_W-1:0]  transfer_length,
	input  wire logic [7:0]                prog_data,
	input  wire logic                      prog_data_valid,
	input  wire logic                      power_down_req,
	input  wire logic                      power_up_req,
	input  wire logic                      target_onchip_flash,
	input  wire logic                      target_auto_detect,
	input  wire logic                      feature_enable,
	input  wire logic                      high_temp_enable,
	input  wire logic                      spi_miso,
	output logic                           busy,
	output logic                           op_done,
	output logic                           op_fail,
	output logic [7:0]                     read_data,
	output logic                           read_data_valid,
	output logic                           prog_data_ready,
	output logic                           flash_err_irq,
	output logic [15:0]                    parity_err_count,
	output logic                           hv_high_temp,
	output logic                           ext_powered_down,
	output logic                           spi_sck,
	output logic                           spi_cs_n,
	output logic                           spi_mosi
);
	localparam int AW = SECTOR_AW + $clog2(SECTORS);
	localparam int DEPTH = SECTORS << SECTOR_AW;

	// The address and mask ports are sized for eight sectors of the packaged width.
	if (SECTORS != 8 || AW != fepc_pkg::ADDR_W) begin : g_bad_size
		$error("fepc_top: sector count must be eight with matching address width");
	end

	// Storage holds data and one parity bit per byte.
	logic [8:0]                  mem [DEPTH];
	fepc_pkg::fepc_state_t       state_ff;
	fepc_pkg::fepc_state_t       nxt_state;
	logic [AW-1:0]               addr_ff;
	logic [fepc_pkg::LEN_W-1:0]  left_ff;
	logic [SECTORS-1:0]          mask_ff;
	logic                        busy_ff;
	logic                        done_ff;
	logic                        fail_ff;
	logic [7:0]                  rdata_ff;
	logic                        rvalid_ff;
	logic                        irq_ff;
	logic [15:0]                 perr_ff;
	logic                        ht_ff;
	logic                        pd_ff;
	logic [7:0]                  shift_ff;
	logic [3:0]                  bits_ff;
	logic [1:0]                  div_ff;
	logic                        sck_ff;
	logic                        cs_n_ff;
	logic                        mosi_ff;
	logic                        miso_meta_ff;
	logic                        miso_sync_ff;
	logic                        wake_pending_ff;
	logic                        prog_rdy_ff;

	wire                         idle       = (state_ff == fepc_pkg::ST_IDLE);
	// Last byte of the request, wide enough that a full-length request does not wrap.
	wire [fepc_pkg::LEN_W:0]     span_end   = (fepc_pkg::LEN_W+1)'(flash_byte_offset)
	                                          + (fepc_pkg::LEN_W+1)'(transfer_length)
	                                          - (fepc_pkg::LEN_W+1)'(1);
	wire                         past_end   = |span_end[fepc_pkg::LEN_W:AW];

	// power commands only for external target
	wire                         ext_target = !target_onchip_flash && !target_auto_detect;
	wire                         prog_ok    = (flash_byte_offset[fepc_pkg::PAGEWORD_LSB-1:0] == '0)
	                                          && (transfer_length[fepc_pkg::PAGEWORD_LSB-1:0] == '0)
	                                          && (transfer_length != '0)
	                                          && (transfer_length <= fepc_pkg::MAX_LEN)
	                                          && !past_end;

	wire                         read_ok    = (transfer_length != '0) && (transfer_length <= fepc_pkg::MAX_LEN)
	                                          && (span_end[AW-1:SECTOR_AW] == flash_byte_offset[AW-1:SECTOR_AW])
	                                          && !past_end;

	wire                         access_ok  = !wake_pending_ff;
	wire                         op_take    = (erase_req || prog_req || read_req) && access_ok;
	// A power command starts only when no array operation is taken in the same cycle.
	wire                         spi_launch = idle && !op_take && ext_target && (power_down_req || power_up_req);

	wire                         sck_tick   = (div_ff == 2'(fepc_pkg::SCK_DIV - 1));
	wire [8:0]                   cur_word   = mem[addr_ff];
	wire                         par_bad    = ^cur_word;
	wire                         last_xfer  = (left_ff == 16'h0001);
	wire [SECTOR_AW-1:0]         addr_low   = addr_ff[SECTOR_AW-1:0];
	wire [$clog2(SECTORS)-1:0]   addr_sec   = addr_ff[AW-1:SECTOR_AW];
	wire                         erase_hit  = mask_ff[addr_sec];
	wire [7:0]                   prog_byte  = cur_word[7:0] & prog_data;
	wire                         prog_step  = (state_ff == fepc_pkg::ST_PROG) && prog_data_valid;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			fepc_pkg::ST_IDLE: begin
				if (erase_req && access_ok)
					nxt_state = fepc_pkg::ST_ERASE;
				else if (prog_req && access_ok)
					nxt_state = prog_ok ? fepc_pkg::ST_PROG : fepc_pkg::ST_FAIL;
				else if (read_req && access_ok)
					nxt_state = read_ok ? fepc_pkg::ST_READ : fepc_pkg::ST_FAIL;
				else if (spi_launch)
					nxt_state = fepc_pkg::ST_SPI;
			end
			fepc_pkg::ST_ERASE: begin
				if (addr_ff == AW'(DEPTH - 1))
					nxt_state = fepc_pkg::ST_DONE;
			end
			fepc_pkg::ST_PROG: begin
				if (prog_step && last_xfer)
					nxt_state = fepc_pkg::ST_DONE;
			end
			fepc_pkg::ST_READ: begin
				if (last_xfer)
					nxt_state = fepc_pkg::ST_DONE;
			end
			fepc_pkg::ST_SPI: begin
				if (sck_tick && sck_ff && bits_ff == 4'h0)
					nxt_state = fepc_pkg::ST_DONE;
			end
			default: nxt_state = fepc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= fepc_pkg::ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Address, length and mask tracking.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_ff <= '0;
			left_ff <= '0;
			mask_ff <= '0;
		end else if (idle) begin
			addr_ff <= erase_req ? '0 : flash_byte_offset;
			left_ff <= transfer_length;
			mask_ff <= sector_erase_mask;
		end else if (state_ff == fepc_pkg::ST_ERASE || state_ff == fepc_pkg::ST_READ || prog_step) begin
			addr_ff <= addr_ff + 1'b1;
			left_ff <= left_ff - 1'b1;
		end
	end

	// Array writes: erase and program.
	always_ff @(posedge core_clk) begin
		if (state_ff == fepc_pkg::ST_ERASE && erase_hit)
			mem[addr_ff] <= {^fepc_pkg::ERASED_BYTE, fepc_pkg::ERASED_BYTE};
		// rewriting a used byte corrupts parity
		else if (prog_step)
			mem[addr_ff] <= {(^prog_byte) ^ (cur_word[7:0] != fepc_pkg::ERASED_BYTE), prog_byte};
	end

	// Read path, error detection and counting.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_ff  <= '0;
			rvalid_ff <= 1'b0;
			irq_ff    <= 1'b0;
			perr_ff   <= fepc_pkg::ERR_CNT_RESET;
		end else begin
			rvalid_ff <= (state_ff == fepc_pkg::ST_READ);
			rdata_ff  <= cur_word[7:0];
			irq_ff    <= (state_ff == fepc_pkg::ST_READ) && par_bad && feature_enable;
			if ((state_ff == fepc_pkg::ST_READ) && par_bad && feature_enable)
				perr_ff <= perr_ff + 16'h0001;
		end
	end

	// Status, high-temperature select and power state.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_ff         <= 1'b0;
			done_ff         <= 1'b0;
			fail_ff         <= 1'b0;
			ht_ff           <= 1'b0;
			pd_ff           <= 1'b0;
			wake_pending_ff <= 1'b0;
			prog_rdy_ff     <= 1'b0;
		end else begin
			busy_ff <= !(nxt_state == fepc_pkg::ST_IDLE);
			prog_rdy_ff <= (nxt_state == fepc_pkg::ST_PROG);

			done_ff <= (state_ff == fepc_pkg::ST_DONE) || (state_ff == fepc_pkg::ST_FAIL);
			if (state_ff == fepc_pkg::ST_DONE || state_ff == fepc_pkg::ST_FAIL)
				fail_ff <= (state_ff == fepc_pkg::ST_FAIL);
			ht_ff <= high_temp_enable;
			if (spi_launch && power_down_req) begin
				pd_ff           <= 1'b1;
				wake_pending_ff <= 1'b1;
			end else if (spi_launch && power_up_req) begin
				pd_ff           <= 1'b0;
				wake_pending_ff <= 1'b0;
			end
		end
	end

	// Serial command shifter, mode 0, SCK at core_clk divided by SCK_DIV pairs.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_ff       <= '0;
			sck_ff       <= 1'b0;
			cs_n_ff      <= 1'b1;
			mosi_ff      <= 1'b0;
			shift_ff     <= '0;
			bits_ff      <= '0;
			miso_meta_ff <= 1'b0;
			miso_sync_ff <= 1'b0;
		end else begin
			miso_meta_ff <= spi_miso;
			miso_sync_ff <= miso_meta_ff;
			div_ff       <= sck_tick ? '0 : div_ff + 2'h1;
			// command launch
			// The first bit is set up with the select, a full half period before the first rise.
			if (spi_launch) begin
				shift_ff <= power_down_req ? fepc_pkg::CMD_POWER_DOWN : fepc_pkg::CMD_POWER_UP;
				mosi_ff  <= power_down_req ? fepc_pkg::CMD_POWER_DOWN[7] : fepc_pkg::CMD_POWER_UP[7];
				bits_ff  <= 4'(fepc_pkg::SPI_BITS);
				cs_n_ff  <= 1'b0;
				sck_ff   <= 1'b0;
				div_ff   <= '0;
			end else if (state_ff == fepc_pkg::ST_SPI && sck_tick) begin
				// Rising edge: the far side samples, the shifter advances.
				if (!sck_ff && bits_ff != 4'h0) begin
					shift_ff <= {shift_ff[6:0], miso_sync_ff};
					bits_ff  <= bits_ff - 4'h1;
					sck_ff   <= 1'b1;
				// Falling edge: the next bit is set up, or the frame closes.
				end else if (sck_ff) begin
					sck_ff  <= 1'b0;
					mosi_ff <= shift_ff[7];
					if (bits_ff == 4'h0)
						cs_n_ff <= 1'b1;
				end
			end
		end
	end

	assign busy             = busy_ff;
	assign op_done          = done_ff;
	assign op_fail          = fail_ff;
	assign read_data        = rdata_ff;
	assign read_data_valid  = rvalid_ff;
	assign prog_data_ready  = prog_rdy_ff;
	assign flash_err_irq    = irq_ff;
	assign parity_err_count = perr_ff;
	assign hv_high_temp     = ht_ff;
	assign ext_powered_down = pd_ff;
	assign spi_sck          = sck_ff;
	assign spi_cs_n         = cs_n_ff;
	assign spi_mosi         = mosi_ff;
endmodule : fepc_top

// >>> common/fepc_pkg.sv
// Constants and types shared by the flash erase/program sequencer.
// Assumes a single core clock domain; nothing here holds logic.
package fepc_pkg;
	localparam int          SECTORS        = 8;
	localparam int          SECTOR_AW      = 12;
	localparam int          ADDR_W         = SECTOR_AW + 3;
	localparam int          LEN_W          = 16;
	localparam logic [15:0] MAX_LEN        = 16'h8000;
	localparam int          PAGEWORD_BYTES = 16;
	localparam int          PAGEWORD_LSB   = 4;
	localparam logic [7:0]  CMD_POWER_DOWN = 8'hb9;
	localparam logic [7:0]  CMD_POWER_UP   = 8'hab;
	localparam logic [7:0]  ERASED_BYTE    = 8'hff;
	localparam logic [15:0] ERR_CNT_RESET  = 16'h0000;
	localparam int          CLK_MHZ        = 125;
	localparam int          SCK_DIV        = 4;
	localparam int          SPI_BITS       = 8;

	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_ERASE = 7'h02,
		ST_PROG  = 7'h04,
		ST_READ  = 7'h08,
		ST_SPI   = 7'h10,
		ST_DONE  = 7'h20,
		ST_FAIL  = 7'h40
	} fepc_state_t;
endpackage : fepc_pkg

// >>> sim/fepc_props.sv
// Port assertions for the flash sequencer, bound to its top module.
// Assumes one core_clk domain with arst_n active low.
`timescale 1ns/100ps
module fepc_props (
	input wire logic        core_clk,
	input wire logic        arst_n,
	input wire logic        read_req,
	input wire logic        feature_enable,
	input wire logic        high_temp_enable,
	input wire logic        busy,
	input wire logic        op_done,
	input wire logic        op_fail,
	input wire logic        read_data_valid,
	input wire logic        flash_err_irq,
	input wire logic [15:0] parity_err_count,
	input wire logic        hv_high_temp,
	input wire logic        ext_powered_down,
	input wire logic        spi_cs_n
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	chk_done_pulse: assert property (op_done |=> !op_done) else $error("done held too long");
	chk_fail_on_done: assert property ($changed(op_fail) |-> op_done) else $error("fail moved alone");
	chk_read_taken: assert property (read_req && !busy && !op_done && !ext_powered_down |=> busy)
		else $error("read not taken");
	chk_byte_in_op: assert property (read_data_valid |-> busy && !op_done) else $error("stray read byte");
	chk_irq_enable: assert property (flash_err_irq |-> feature_enable) else $error("irq while disabled");
	chk_count_step: assert property ($changed(parity_err_count) |->
		parity_err_count == $past(parity_err_count) + 16'h0001) else $error("count jumped");
	chk_select_busy: assert property (!spi_cs_n |-> busy) else $error("select while idle");
	chk_hv_follow: assert property ($stable(high_temp_enable) [*3] |->
		hv_high_temp == high_temp_enable) else $error("voltage select wrong");
	cover property (op_done && op_fail);
	cover property (read_data_valid);
	cover property (!spi_cs_n);
	cover property (flash_err_irq);
endmodule : fepc_props
bind fepc_top fepc_props CHK (.*);

// >>> sim/fepc_spi_flash.sv
// Behavioural external serial flash that decodes one-byte commands.
// Assumes bits are taken on the rising serial clock, most significant first.
`timescale 1ns/100ps
module fepc_spi_flash (
	input  wire logic  spi_sck,
	input  wire logic  spi_cs_n,
	input  wire logic  spi_mosi,
	output logic       spi_miso,
	output logic [7:0] last_cmd = 8'h00,
	output logic       asleep = 1'b0,
	output logic       bad_access = 1'b0
);
	logic [7:0] sh = 8'h00;
	int         nbits = 0;
	// Nothing is answered, so the data line keeps moving.
	assign spi_miso = ~sh[0];
	always @(negedge spi_cs_n) nbits = 0;
	always @(posedge spi_sck) if (!spi_cs_n && ++nbits <= 8) begin
		sh = {sh[6:0], spi_mosi};
		if (nbits == 8 && asleep && sh != fepc_pkg::CMD_POWER_UP) bad_access = 1'b1;
		if (nbits == 8) last_cmd = sh;
		if (nbits == 8) asleep = (sh == fepc_pkg::CMD_POWER_DOWN) || (asleep && sh != fepc_pkg::CMD_POWER_UP);
	end
endmodule : fepc_spi_flash

// >>> sim/fepc_top_bench.sv
// Self-checking bench for the flash sequencer with a serial flash model.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/100ps
module fepc_top_bench;
	logic        core_clk, arst_n, erase_req, prog_req, read_req, power_down_req, power_up_req, prog_data_valid;
	logic        target_onchip_flash, target_auto_detect, feature_enable, high_temp_enable, spi_miso, busy;
	logic        op_done, op_fail, read_data_valid, prog_data_ready, flash_err_irq, hv_high_temp, ext_powered_down;
	logic        spi_sck, spi_cs_n, spi_mosi, asleep, bad_access;
	logic [7:0]  sector_erase_mask, prog_data, read_data, last_cmd, got[$];
	logic [14:0] flash_byte_offset;
	logic [15:0] transfer_length, parity_err_count;
	int          n_errors, checks, cyc, n_irq;
	fepc_top DUT (.*);
	fepc_spi_flash FLASH (.*);
	initial forever #4 core_clk = ~core_clk;
	task automatic results();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		n_errors += (seen !== exp);
		if (seen !== exp) $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
	endtask : chk
	task automatic go(input logic [4:0] k, input logic [14:0] off, input logic [15:0] len);
		@(posedge core_clk);
		{erase_req, prog_req, read_req, power_down_req, power_up_req} <= k;
		flash_byte_offset <= off;
		transfer_length <= len;
		@(posedge core_clk);
		{erase_req, prog_req, read_req, power_down_req, power_up_req} <= 5'h00;
	endtask : go
	task automatic wait_end(input logic use_done);
		got.delete();
		@(negedge core_clk);
		while (use_done ? op_done !== 1'b1 : busy === 1'b1) begin
			if (read_data_valid === 1'b1) got.push_back(read_data);
			@(negedge core_clk);
		end
	endtask : wait_end
	task automatic prog(input logic [14:0] off, input logic [15:0] len, input logic fail);
		logic r;
		go(5'h08, off, len);
		prog_data <= 8'h5a;
		prog_data_valid <= !fail;
		for (int i = 0; !fail && i < len; ) begin
			@(negedge core_clk);
			r = prog_data_ready;
			@(posedge core_clk);
			i += r;
			prog_data <= 8'h5a ^ 8'(i);
		end
		prog_data_valid <= 1'b0;
		wait_end(1'b1);
		chk(op_fail, fail);
	endtask : prog
	task automatic t_erase();
		sector_erase_mask <= 8'h03;
		go(5'h10, 15'h0000, 16'h0000);
		wait_end(1'b1);
		chk(op_fail, 1'b0);
		go(5'h04, 15'h0020, 16'h0020);
		wait_end(1'b1);
		chk(16'(got.size()), 16'h0020);
		for (int j = 0; j < 32; j++) chk(got[j], 8'hff);
		$display("erase test done");
	endtask : t_erase
	task automatic t_prog();
		prog(15'h0010, 16'h0010, 1'b0);
		go(5'h04, 15'h0000, 16'h0020);
		wait_end(1'b1);
		for (int j = 0; j < 32; j++) chk(got[j], j < 16 ? 8'hff : 8'h5a ^ 8'(j - 16));
		chk(parity_err_count, 16'h0000);
		chk(hv_high_temp, 1'b1);
		prog(15'h0008, 16'h0010, 1'b1);
		prog(15'h0000, 16'h8010, 1'b1);
		go(5'h04, 15'h0ff0, 16'h0020);
		wait_end(1'b1);
		chk(16'(got.size()), 16'h0000);
		chk(op_fail, 1'b1);
		$display("program test done");
	endtask : t_prog
	task automatic t_parity();
		prog(15'h0010, 16'h0010, 1'b0);
		go(5'h04, 15'h0010, 16'h0010);
		wait_end(1'b1);
		chk(16'(n_irq), 16'h0010);
		chk(parity_err_count, 16'h0010);
		@(posedge core_clk) feature_enable <= 1'b0;
		go(5'h04, 15'h0010, 16'h0010);
		wait_end(1'b1);
		chk(16'(got.size()), 16'h0010);
		chk(16'(n_irq), 16'h0010);
		chk(parity_err_count, 16'h0010);
		@(posedge core_clk) high_temp_enable <= 1'b0;
		repeat (4) @(negedge core_clk);
		chk(hv_high_temp, 1'b0);
		$display("parity test done");
	endtask : t_parity
	task automatic t_power();
		go(5'h02, 15'h0000, 16'h0000);
		wait_end(1'b0);
		chk(ext_powered_down, 1'b0);
		chk(last_cmd, 8'h00);
		@(posedge core_clk) target_onchip_flash <= 1'b0;
		go(5'h02, 15'h0000, 16'h0000);
		wait_end(1'b0);
		chk(last_cmd, fepc_pkg::CMD_POWER_DOWN);
		chk(ext_powered_down, 1'b1);
		go(5'h04, 15'h0020, 16'h0001);
		wait_end(1'b0);
		chk(16'(got.size()), 16'h0000);
		chk(busy, 1'b0);
		go(5'h01, 15'h0000, 16'h0000);
		wait_end(1'b0);
		chk(last_cmd, fepc_pkg::CMD_POWER_UP);
		chk(bad_access, 1'b0);
		$display("power test done");
	endtask : t_power
	initial begin
		core_clk = 1'b0;
		{arst_n, erase_req, prog_req, read_req, power_down_req, power_up_req, prog_data_valid} = 7'h00;
		{target_auto_detect, sector_erase_mask, prog_data, flash_byte_offset, transfer_length} = 48'h0;
		{target_onchip_flash, feature_enable, high_temp_enable} = 3'h7;
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b1;
		t_erase();
		t_prog();
		t_parity();
		t_power();
		results();
	end
	always @(posedge core_clk) if (flash_err_irq === 1'b1) n_irq++;
	always @(posedge core_clk) if (++cyc == 90000) begin
		n_errors++;
		$display("MISMATCH t=%0t timeout", $time);
		results();
	end
endmodule : fepc_top_bench
